// [audio_and_trim_converter_regs.sv]
/*
 * Register file and output control for the audio converter and the
 * trim (reference) converter. Six byte registers on a plain strobe bus.
 * Assumes bus master on CLOCK, one-cycle strobes, never both at once.
 */
// How it works
// - audio enable bit switches audio converter
// - audio enable zero holds power down
// - disabled audio ignores its data registers
// - volume field bits 7 to 5, eight levels
// - audio control bits 4 to 1 read zero
// - audio high byte holds sample 11 to 4
// - audio low upper nibble holds sample 3 to 0
// - trim control bit 0 enables trim converter
// - trim control bits 7 to 1 read zero
// - trim high byte holds code 9 to 2
// - trim low bits 7,6 hold code 1,0
`include "conv_regs.svh"
`timescale 1ns/1ps
module audio_and_trim_converter_regs #(
    parameter int ADDR_WIDTH = `CONV_ADDR_WIDTH
) (
    input  wire logic                          CLOCK,
    input  wire logic                          RSTN,
    input  wire logic                          CLOCK_ENABLE,
    input  wire logic [ADDR_WIDTH-1:0]         REG_ADDR,
    input  wire logic [`CONV_DATA_WIDTH-1:0]   REG_WDATA,
    input  wire logic                          REG_WRITE,
    input  wire logic                          REG_READ,
    output logic [`CONV_DATA_WIDTH-1:0]        REG_RDATA,
    output logic                               AUDIO_POWER_ON,
    output logic                               AUDIO_POWER_DOWN,
    output logic [`VOLUME_WIDTH-1:0]           AUDIO_VOLUME,
    output logic [`AUDIO_SAMPLE_WIDTH-1:0]     AUDIO_SAMPLE,
    output logic                               TRIM_POWER_ON,
    output logic                               TRIM_POWER_DOWN,
    output logic [`TRIM_CODE_WIDTH-1:0]        TRIM_CODE
);

    localparam int HIGH_WIDTH = `CONV_DATA_WIDTH;

    logic                          audio_enable_q;
    logic [`VOLUME_WIDTH-1:0]      volume_level_q;
    logic [`AUDIO_LOW_WIDTH-1:0]   audio_low_q;
    logic [HIGH_WIDTH-1:0]         audio_high_q;
    logic                          trim_enable_q;
    logic [`TRIM_LOW_WIDTH-1:0]    trim_low_q;
    logic [HIGH_WIDTH-1:0]         trim_high_q;
    logic [`CONV_DATA_WIDTH-1:0]   rdata_d;
    conv_pkg::reg_sel_type         wr_sel;
    conv_pkg::reg_sel_type         rd_sel;

    conv_out_if #(.WIDTH(`AUDIO_SAMPLE_WIDTH)) audio_link ();
    conv_out_if #(.WIDTH(`TRIM_CODE_WIDTH))    trim_link ();

    // shared by write and read decode
    function automatic conv_pkg::reg_sel_type reg_select(
        input logic [ADDR_WIDTH-1:0] addr
    );
        conv_pkg::reg_sel_type sel;
        sel = conv_pkg::SEL_NONE;
        case (addr)
            ADDR_WIDTH'(`AUDIO_CONV_CONTROL_OFS):  sel = conv_pkg::SEL_AUDIO_CTRL;
            ADDR_WIDTH'(`AUDIO_CONV_DATA_LOW_OFS): sel = conv_pkg::SEL_AUDIO_LOW;
            ADDR_WIDTH'(`AUDIO_CONV_DATA_HIGH_OFS): sel = conv_pkg::SEL_AUDIO_HIGH;
            ADDR_WIDTH'(`TRIM_CONV_CONTROL_OFS):   sel = conv_pkg::SEL_TRIM_CTRL;
            ADDR_WIDTH'(`TRIM_CONV_DATA_LOW_OFS):  sel = conv_pkg::SEL_TRIM_LOW;
            ADDR_WIDTH'(`TRIM_CONV_DATA_HIGH_OFS): sel = conv_pkg::SEL_TRIM_HIGH;
            default:                               sel = conv_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction

    assign wr_sel = REG_WRITE ? reg_select(REG_ADDR) : conv_pkg::SEL_NONE;
    assign rd_sel = reg_select(REG_ADDR);

    // audio control: only volume and enable are stored
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            audio_enable_q <= 1'b0;
            volume_level_q <= '0;
        end else if (CLOCK_ENABLE && wr_sel == conv_pkg::SEL_AUDIO_CTRL) begin
            audio_enable_q <= REG_WDATA[`AUDIO_ENABLE_BIT];
            volume_level_q <= REG_WDATA[`VOLUME_MSB:`VOLUME_LSB];
        end
    end

    // audio sample bytes
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            audio_low_q  <= '0;
            audio_high_q <= '0;
        end else if (CLOCK_ENABLE) begin
            if (wr_sel == conv_pkg::SEL_AUDIO_LOW) begin
                audio_low_q <= REG_WDATA[`AUDIO_LOW_MSB:`AUDIO_LOW_LSB];
            end
            if (wr_sel == conv_pkg::SEL_AUDIO_HIGH) begin
                audio_high_q <= REG_WDATA;
            end
        end
    end

    // trim control and code bytes
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            trim_enable_q <= 1'b0;
            trim_low_q    <= '0;
            trim_high_q   <= '0;
        end else if (CLOCK_ENABLE) begin
            if (wr_sel == conv_pkg::SEL_TRIM_CTRL) begin
                trim_enable_q <= REG_WDATA[`TRIM_ENABLE_BIT];
            end
            if (wr_sel == conv_pkg::SEL_TRIM_LOW) begin
                trim_low_q <= REG_WDATA[`TRIM_LOW_MSB:`TRIM_LOW_LSB];
            end
            if (wr_sel == conv_pkg::SEL_TRIM_HIGH) begin
                trim_high_q <= REG_WDATA;
            end
        end
    end

    // readback: unimplemented bits stay at the zero reset value
    always_comb begin
        rdata_d = `REG_RESET_VALUE;
        case (rd_sel)
            conv_pkg::SEL_AUDIO_CTRL: begin
                rdata_d[`VOLUME_MSB:`VOLUME_LSB] = volume_level_q;
                rdata_d[`AUDIO_ENABLE_BIT]       = audio_enable_q;
            end
            conv_pkg::SEL_AUDIO_LOW: begin
                rdata_d[`AUDIO_LOW_MSB:`AUDIO_LOW_LSB] = audio_low_q;
            end
            conv_pkg::SEL_AUDIO_HIGH: begin
                rdata_d = audio_high_q;
            end
            conv_pkg::SEL_TRIM_CTRL: begin
                rdata_d[`TRIM_ENABLE_BIT] = trim_enable_q;
            end
            conv_pkg::SEL_TRIM_LOW: begin
                rdata_d[`TRIM_LOW_MSB:`TRIM_LOW_LSB] = trim_low_q;
            end
            conv_pkg::SEL_TRIM_HIGH: begin
                rdata_d = trim_high_q;
            end
            default: begin
                rdata_d = `UNMAPPED_READ_VALUE;
            end
        endcase
    end

    // read data is loaded at the strobe's enabled edge and clears at the next enabled edge
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= `REG_RESET_VALUE;
        end else if (CLOCK_ENABLE) begin
            REG_RDATA <= REG_READ ? rdata_d : `REG_RESET_VALUE;
        end
    end

    // volume is applied whether or not the core is on
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            AUDIO_VOLUME <= '0;
        end else if (CLOCK_ENABLE) begin
            AUDIO_VOLUME <= volume_level_q;
        end
    end

    assign audio_link.enable = audio_enable_q;
    assign audio_link.code   = {audio_high_q, audio_low_q};
    assign trim_link.enable  = trim_enable_q;
    assign trim_link.code    = {trim_high_q, trim_low_q};

    conv_output_stage #(.WIDTH(`AUDIO_SAMPLE_WIDTH)) audio_stage (
        .clock        (CLOCK),
        .rst_n        (RSTN),
        .clock_enable (CLOCK_ENABLE),
        .from_regs    (audio_link),
        .power_on     (AUDIO_POWER_ON),
        .power_down   (AUDIO_POWER_DOWN),
        .code         (AUDIO_SAMPLE)
    );

    conv_output_stage #(.WIDTH(`TRIM_CODE_WIDTH)) trim_stage (
        .clock        (CLOCK),
        .rst_n        (RSTN),
        .clock_enable (CLOCK_ENABLE),
        .from_regs    (trim_link),
        .power_on     (TRIM_POWER_ON),
        .power_down   (TRIM_POWER_DOWN),
        .code         (TRIM_CODE)
    );

endmodule

// [conv_regs.svh]
/*
 * Register offsets, field positions, reset values and widths for the
 * audio converter and trim converter control registers.
 * Assumes it is included by its bare name and defines nothing else.
 */
`ifndef CONV_REGS_SVH
`define CONV_REGS_SVH

`define CONV_ADDR_WIDTH        3
`define CONV_DATA_WIDTH        8

`define AUDIO_CONV_CONTROL_OFS 3'h0
`define AUDIO_CONV_DATA_LOW_OFS 3'h1
`define AUDIO_CONV_DATA_HIGH_OFS 3'h2
`define TRIM_CONV_CONTROL_OFS  3'h3
`define TRIM_CONV_DATA_LOW_OFS 3'h4
`define TRIM_CONV_DATA_HIGH_OFS 3'h5

`define REG_RESET_VALUE        8'h00
`define UNMAPPED_READ_VALUE    8'h00

`define VOLUME_MSB             7
`define VOLUME_LSB             5
`define VOLUME_WIDTH           3
`define AUDIO_ENABLE_BIT       0
`define AUDIO_LOW_MSB          7
`define AUDIO_LOW_LSB          4
`define AUDIO_LOW_WIDTH        4
`define AUDIO_SAMPLE_WIDTH     12

`define TRIM_ENABLE_BIT        0
`define TRIM_LOW_MSB           7
`define TRIM_LOW_LSB           6
`define TRIM_LOW_WIDTH         2
`define TRIM_CODE_WIDTH        10

`endif

// [conv_pkg.sv]
/*
 * Types shared by the converter register block.
 * Assumes conv_regs.svh supplies all numeric constants.
 */
package conv_pkg;

    typedef enum logic [2:0] {
        SEL_NONE        = 3'h0,
        SEL_AUDIO_CTRL  = 3'h1,
        SEL_AUDIO_LOW   = 3'h3,
        SEL_AUDIO_HIGH  = 3'h2,
        SEL_TRIM_CTRL   = 3'h6,
        SEL_TRIM_LOW    = 3'h7,
        SEL_TRIM_HIGH   = 3'h5
    } reg_sel_type;

endpackage

// [conv_out_if.sv]
/*
 * Carrier from the register file to one converter output stage:
 * the enable and the assembled code word.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface conv_out_if #(
    parameter int WIDTH = 12
);
    logic             enable;
    logic [WIDTH-1:0] code;

    modport src (output enable, output code);
    modport dst (input enable, input code);
endinterface

// [conv_output_stage.sv]
/*
 * Output flops for one converter core: power on, power down, code.
 * Assumes a register file drives the interface on the same clock.
 */
`timescale 1ns/1ps
module conv_output_stage #(
    parameter int WIDTH = 12
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             clock_enable,
    conv_out_if.dst               from_regs,
    output logic                  power_on,
    output logic                  power_down,
    output logic [WIDTH-1:0]      code
);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            power_on   <= 1'b0;
            power_down <= 1'b1;
        end else if (clock_enable) begin
            power_on   <= from_regs.enable;
            power_down <= !from_regs.enable;
        end
    end

    // code is forced to zero while off, so stale data cannot leak
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            code <= '0;
        end else if (clock_enable) begin
            if (from_regs.enable) begin
                code <= from_regs.code;
            end else begin
                code <= '0;
            end
        end
    end

endmodule

// [audio_and_trim_converter_regs_chk.sv]
/*
 * Port-level assertions for the converter register block.
 * Assumes it is bound to the top module; one clock, async low reset.
 */
`timescale 1ns/1ps
module audio_and_trim_converter_regs_chk #(
    parameter int ADDR_WIDTH = 3
) (
    input wire logic                  CLOCK,
    input wire logic                  RSTN,
    input wire logic                  CLOCK_ENABLE,
    input wire logic [ADDR_WIDTH-1:0] REG_ADDR,
    input wire logic [7:0]            REG_WDATA,
    input wire logic                  REG_WRITE,
    input wire logic                  REG_READ,
    input wire logic [7:0]            REG_RDATA,
    input wire logic                  AUDIO_POWER_ON,
    input wire logic                  AUDIO_POWER_DOWN,
    input wire logic [2:0]            AUDIO_VOLUME,
    input wire logic [11:0]           AUDIO_SAMPLE,
    input wire logic                  TRIM_POWER_ON,
    input wire logic                  TRIM_POWER_DOWN,
    input wire logic [9:0]            TRIM_CODE
);
    logic wr_ok;
    logic rd_ok;
    assign wr_ok = CLOCK_ENABLE && REG_WRITE;
    assign rd_ok = CLOCK_ENABLE && REG_READ;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    AST_AUD_DOWN: assert property (AUDIO_POWER_DOWN != AUDIO_POWER_ON)
        else $error("audio power down not inverse of power on");
    AST_TRIM_DOWN: assert property (TRIM_POWER_DOWN != TRIM_POWER_ON)
        else $error("trim power down not inverse of power on");
    AST_AUD_GATE: assert property (!AUDIO_POWER_ON |-> AUDIO_SAMPLE == 12'h000)
        else $error("sample shown while audio disabled");
    AST_TRIM_GATE: assert property (!TRIM_POWER_ON |-> TRIM_CODE == 10'h000)
        else $error("code shown while trim disabled");
    AST_AUD_EN: assert property ((wr_ok && REG_ADDR == 3'h0) ##1 CLOCK_ENABLE |=> AUDIO_POWER_ON == $past(REG_WDATA[0], 2))
        else $error("audio enable not applied");
    AST_VOLUME: assert property ((wr_ok && REG_ADDR == 3'h0) ##1 CLOCK_ENABLE |=> AUDIO_VOLUME == $past(REG_WDATA[7:5], 2))
        else $error("volume not applied");
    AST_TRIM_EN: assert property ((wr_ok && REG_ADDR == 3'h3) ##1 CLOCK_ENABLE |=> TRIM_POWER_ON == $past(REG_WDATA[0], 2))
        else $error("trim enable not applied");
    AST_RD_CTRL: assert property (rd_ok && REG_ADDR == 3'h0 |=> REG_RDATA[4:1] == 4'h0)
        else $error("audio control unused bits read nonzero");
    AST_RD_TRIM: assert property (rd_ok && REG_ADDR == 3'h3 |=> REG_RDATA[7:1] == 7'h00)
        else $error("trim control unused bits read nonzero");
    AST_RD_LOW: assert property (rd_ok && REG_ADDR == 3'h4 |=> REG_RDATA[5:0] == 6'h00)
        else $error("trim low unused bits read nonzero");
endmodule

// [audio_and_trim_converter_regs_bench.sv]
/*
 * Self-checking bench for the converter register block with a byte model.
 * Assumes offsets 0 to 5 for the six registers and 6, 7 unmapped.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    errors++; $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module audio_and_trim_converter_regs_bench;
    logic        CLOCK, RSTN, CLOCK_ENABLE, REG_WRITE, REG_READ;
    logic [2:0]  REG_ADDR, AUDIO_VOLUME;
    logic [7:0]  REG_WDATA, REG_RDATA;
    logic        AUDIO_POWER_ON, AUDIO_POWER_DOWN;
    logic        TRIM_POWER_ON, TRIM_POWER_DOWN;
    logic [11:0] AUDIO_SAMPLE;
    logic [9:0]  TRIM_CODE;
    int          errors, total_checks, cycles;
    logic [7:0]  m [8];
    logic [7:0]  mask [8] = '{8'hE1, 8'hF0, 8'hFF, 8'h01, 8'hC0, 8'hFF,
                              8'h00, 8'h00};
    audio_and_trim_converter_regs audio_and_trim_converter_regs_i (
        .CLOCK(CLOCK), .RSTN(RSTN), .CLOCK_ENABLE(CLOCK_ENABLE),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE),
        .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
        .AUDIO_POWER_ON(AUDIO_POWER_ON), .AUDIO_POWER_DOWN(AUDIO_POWER_DOWN),
        .AUDIO_VOLUME(AUDIO_VOLUME), .AUDIO_SAMPLE(AUDIO_SAMPLE),
        .TRIM_POWER_ON(TRIM_POWER_ON), .TRIM_POWER_DOWN(TRIM_POWER_DOWN),
        .TRIM_CODE(TRIM_CODE));
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ce low: strobe must be ignored, so the model skips it
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input bit ce);
        @(posedge CLOCK);
        REG_WRITE <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        CLOCK_ENABLE <= ce;
        @(posedge CLOCK);
        REG_WRITE <= 1'b0;
        CLOCK_ENABLE <= 1'b1;
        if (ce) m[a] = d & mask[a];
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge CLOCK);
        REG_READ <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLOCK);
        REG_READ <= 1'b0;
        @(negedge CLOCK);
        `CHK("read data", m[a], REG_RDATA)
    endtask
    task automatic chk_out;
        @(posedge CLOCK);
        @(negedge CLOCK);
        `CHK("audio on", m[0][0], AUDIO_POWER_ON)
        `CHK("audio down", !m[0][0], AUDIO_POWER_DOWN)
        `CHK("volume", m[0][7:5], AUDIO_VOLUME)
        `CHK("sample", m[0][0] ? {m[2], m[1][7:4]} : 12'h000, AUDIO_SAMPLE)
        `CHK("trim on", m[3][0], TRIM_POWER_ON)
        `CHK("trim down", !m[3][0], TRIM_POWER_DOWN)
        `CHK("trim code", m[3][0] ? {m[5], m[4][7:6]} : 10'h000, TRIM_CODE)
    endtask
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    // whole run is about 1000 cycles
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        {RSTN, REG_WRITE, REG_READ, REG_ADDR, REG_WDATA} = '0;
        CLOCK_ENABLE = 1'b1;
        errors = 0;
        total_checks = 0;
        cycles = 0;
        foreach (m[i]) m[i] = 8'h00;
        void'($urandom(32'hac8679fd));
        repeat (3) @(posedge CLOCK);
        RSTN <= 1'b1;
        for (int i = 0; i < 8; i++) rd(3'(i));
        for (int k = 0; k < 200; k++) begin
            wr(3'($urandom % 8), 8'($urandom), ($urandom % 8) != 0);
            if ($urandom % 2) chk_out();
            rd(3'($urandom % 8));
        end
        for (int v = 0; v < 8; v++) begin
            wr(3'h0, {3'(v), 4'hF, v[0]}, 1'b1);
            chk_out();
        end
        // mid-run reset must clear every stored bit
        @(posedge CLOCK);
        RSTN <= 1'b0;
        repeat (2) @(posedge CLOCK);
        RSTN <= 1'b1;
        foreach (m[i]) m[i] = 8'h00;
        chk_out();
        for (int i = 0; i < 8; i++) rd(3'(i));
        conclude();
    end
endmodule
bind audio_and_trim_converter_regs audio_and_trim_converter_regs_chk #(
    .ADDR_WIDTH(ADDR_WIDTH)) chk_i (
    .CLOCK(CLOCK), .RSTN(RSTN), .CLOCK_ENABLE(CLOCK_ENABLE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE),
    .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
    .AUDIO_POWER_ON(AUDIO_POWER_ON), .AUDIO_POWER_DOWN(AUDIO_POWER_DOWN),
    .AUDIO_VOLUME(AUDIO_VOLUME), .AUDIO_SAMPLE(AUDIO_SAMPLE),
    .TRIM_POWER_ON(TRIM_POWER_ON), .TRIM_POWER_DOWN(TRIM_POWER_DOWN),
    .TRIM_CODE(TRIM_CODE));
